// *** sil_pkg.sv ***
// Functional notes
// - all reset sources share one highest priority
// - break forces cpu to software interrupt vector
// - break with clear disabled protects peripheral flags
// - clear enabled: flags clear, stay cleared afterwards
// - two-step clears protected until break ends
// - wait or stop clears interrupt mask, stops cpu
// - wait stops cpu clocks, peripherals keep running
// - wait wakeup stacks one cycle after interrupt
// - reset or break exits wait; break sets flag
// - watchdog enabled and running when disable bit zero
// - stop resets counter, gates clocks, wakes on events
// - stop wakeup stacks only after recovery elapses
// - stop gates both oscillator clocks, 2x optionally kept
// - recovery 4096 or 32 4x clock cycles
// - counter held until recovery, then times it
// - reset status clears itself after read
// - power-on sets its flag, clears all others
// - other sources set only their own flag
// - monitor flag when erased vector, no test voltage
// - break clear enable bit is read/write
// - software interrupt is never masked
package sil_pkg;

   // register port map
   localparam logic [7:0] SIL_ADDR_RST_STAT = 8'h00;
   localparam logic [7:0] SIL_ADDR_BRK_CTL = 8'h01;

   // reset_source_status bit positions
   localparam int SIL_BIT_POR = 7;
   localparam int SIL_BIT_PIN = 6;
   localparam int SIL_BIT_WDOG = 5;
   localparam int SIL_BIT_ILLOP = 4;
   localparam int SIL_BIT_ILLEGAL_ADDRESS_FLAG = 3;
   localparam int SIL_BIT_MON = 2;
   localparam int SIL_BIT_LVI = 1;
   localparam logic [7:0] SIL_RST_STAT_RESET = 8'h80;

   // break_flag_control bit positions
   localparam int SIL_BIT_BREAK_CLEAR_ENABLE = 7;
   localparam logic SIL_BREAK_CLEAR_ENABLE_RESET = 1'b0;

   // erased reset vector byte
   localparam logic [7:0] SIL_VEC_ERASED = 8'hFF;

   // stop recovery, in 4x oscillator cycles
   localparam int SIL_RCNT_W = 13;
   localparam logic [SIL_RCNT_W-1:0] SIL_RECOV_LONG = 13'h1000;
   localparam logic [SIL_RCNT_W-1:0] SIL_RECOV_SHORT = 13'h0020;

   typedef enum logic [1:0] {SIL_RUN, SIL_WAIT, SIL_STOP, SIL_RECOV} sil_mode_t;

   // same-domain reset requests
   typedef struct packed {
      logic wdog;
      logic illop;
      logic illegal_address_flag;
   } sil_rst_src_t;

   // clock enables handed to the clock tree
   typedef struct packed {
      logic cpu_en;
      logic periph_en;
      logic osc_x2_en;
      logic osc_x4_en;
   } sil_clk_t;

endpackage : sil_pkg

// *** sil_sync.sv ***
`timescale 1ns/1ps
module sil_sync
   import sil_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sil_sync_t;

   sil_sync_t s_r;
   sil_sync_t s_nxt;

   // stage1 feeds stage2 only; nothing else looks at it
   always_comb begin
      s_nxt.stage1 = async_i;
      s_nxt.stage2 = s_r.stage1;
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_o = s_r.stage2;

endmodule : sil_sync

// *** sil_recov.sv ***
`timescale 1ns/1ps
module sil_recov
   import sil_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // control
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic short_i,
   // recovery elapsed, one-cycle pulse
   output logic done_o
);

   typedef struct packed {
      logic [SIL_RCNT_W-1:0] cnt;
      logic done;
   } sil_rcv_t;

   sil_rcv_t r_r;
   sil_rcv_t r_nxt;
   logic [SIL_RCNT_W-1:0] target;

   always_comb begin
      r_nxt = r_r;
      r_nxt.done = 1'b0;
      target = short_i ? SIL_RECOV_SHORT : SIL_RECOV_LONG;
      if (!run_i) begin
         r_nxt.cnt = '0;
      end else if (tick_i && !r_r.done) begin
         if (r_r.cnt == target - 13'h0001) begin
            r_nxt.done = 1'b1;
            r_nxt.cnt = '0;
         end else begin
            r_nxt.cnt = r_r.cnt + 13'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign done_o = r_r.done;

endmodule : sil_recov

// *** sil_ctl.sv ***
`timescale 1ns/1ps
module sil_ctl
   import sil_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // cpu core
   input wire logic cpu_wait_i,
   input wire logic cpu_stop_i,
   input wire logic cpu_swi_i,
   output logic int_stack_o,
   output logic vector_swi_o,
   output logic mask_clear_o,
   output logic break_state_o,
   output logic sys_reset_o,
   // peripherals and break module
   input wire logic irq_req_i,
   input wire logic break_irq_i,
   input wire logic break_exit_i,
   input wire logic break_stop_wait_flag_clear_i,
   output logic break_stop_wait_flag_o,
   output logic flag_clear_allow_o,
   // reset sources
   input wire sil_rst_src_t rst_src_i,
   input wire logic rst_pin_i,
   input wire logic lvi_pin_i,
   input wire logic irq_vtst_i,
   input wire logic mon_check_i,
   input wire logic [7:0] vec_hi_i,
   input wire logic [7:0] vec_lo_i,
   // configuration and clock control
   input wire logic watchdog_disable_i,
   input wire logic short_recovery_select_i,
   input wire logic osc_enable_in_stop_i,
   output sil_clk_t clk_en_o,
   output logic watchdog_en_o
);

   typedef struct packed {
      sil_mode_t mode;
      logic in_break;
      logic wake_brk;
      logic por_win;
      logic [7:0] rst_stat;
      logic break_clear_enable;
      logic break_stop_wait_flag;
      logic [7:0] rdata;
      logic rst_req;
      logic mask_clr;
      logic stack;
      logic vec_swi;
      logic clr_allow;
      logic wdog_en;
      logic div;
      sil_clk_t clk;
   } sil_state_t;

   localparam sil_clk_t SIL_CLK_RESET = '{
      cpu_en: 1'b1, periph_en: 1'b1, osc_x2_en: 1'b0, osc_x4_en: 1'b1
   };
   localparam sil_state_t SIL_ST_RESET = '{
      mode: SIL_RUN,
      in_break: 1'b0,
      wake_brk: 1'b0,
      por_win: 1'b1,
      rst_stat: SIL_RST_STAT_RESET,
      break_clear_enable: SIL_BREAK_CLEAR_ENABLE_RESET,
      break_stop_wait_flag: 1'b0,
      rdata: 8'h00,
      rst_req: 1'b0,
      mask_clr: 1'b0,
      stack: 1'b0,
      vec_swi: 1'b0,
      clr_allow: 1'b1,
      wdog_en: 1'b0,
      div: 1'b0,
      clk: SIL_CLK_RESET
   };

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   sil_state_t s;
   sil_state_t s_nxt;
   logic [2:0] pin_sync;
   logic rec_done;
   logic pin_rst;
   logic lvi_rst;
   logic vtst;
   logic mon_hit;
   logic any_rst;
   logic rd_stat;

   // reset pin, low-voltage detector and test-voltage level are asynchronous
   sil_sync #(
      .W(3)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .async_i({irq_vtst_i, lvi_pin_i, rst_pin_i}),
      .sync_o(pin_sync)
   );

   // counter only runs in recovery, so it is held through all of stop
   sil_recov u_recov (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .run_i(s.mode == SIL_RECOV),
      .tick_i(s.clk.osc_x4_en),
      .short_i(short_recovery_select_i),
      .done_o(rec_done)
   );

   always_comb begin
      s_nxt = s;
      s_nxt.rst_req = 1'b0;
      s_nxt.mask_clr = 1'b0;
      s_nxt.stack = 1'b0;
      s_nxt.vec_swi = 1'b0;
      s_nxt.rdata = 8'h00;
      pin_rst = pin_sync[0];
      lvi_rst = pin_sync[1];
      vtst = pin_sync[2];
      mon_hit = mon_check_i && s.por_win && !vtst &&
                vec_hi_i == SIL_VEC_ERASED && vec_lo_i == SIL_VEC_ERASED;
      // no arbitration: every source raises the same request
      any_rst = pin_rst || lvi_rst || rst_src_i.wdog || rst_src_i.illop ||
                rst_src_i.illegal_address_flag || mon_hit;
      rd_stat = reg_rd_i && reg_hit(reg_addr_i, SIL_ADDR_RST_STAT);

      if (mon_check_i) begin
         s_nxt.por_win = 1'b0;
      end

      // read data valid only in the cycle after the strobe
      if (reg_rd_i) begin
         if (reg_hit(reg_addr_i, SIL_ADDR_RST_STAT)) begin
            s_nxt.rdata = s.rst_stat;
         end else if (reg_hit(reg_addr_i, SIL_ADDR_BRK_CTL)) begin
            s_nxt.rdata[SIL_BIT_BREAK_CLEAR_ENABLE] = s.break_clear_enable;
         end
      end
      if (reg_wr_i && reg_hit(reg_addr_i, SIL_ADDR_BRK_CTL)) begin
         s_nxt.break_clear_enable = reg_wdata_i[SIL_BIT_BREAK_CLEAR_ENABLE];
      end

      // clear on read first; a source in the same cycle still lands
      if (rd_stat) begin
         s_nxt.rst_stat = 8'h00;
      end
      if (pin_rst) begin
         s_nxt.rst_stat[SIL_BIT_PIN] = 1'b1;
      end
      if (lvi_rst) begin
         s_nxt.rst_stat[SIL_BIT_LVI] = 1'b1;
      end
      if (rst_src_i.wdog) begin
         s_nxt.rst_stat[SIL_BIT_WDOG] = 1'b1;
      end
      if (rst_src_i.illop) begin
         s_nxt.rst_stat[SIL_BIT_ILLOP] = 1'b1;
      end
      if (rst_src_i.illegal_address_flag) begin
         s_nxt.rst_stat[SIL_BIT_ILLEGAL_ADDRESS_FLAG] = 1'b1;
      end
      if (mon_hit) begin
         s_nxt.rst_stat[SIL_BIT_MON] = 1'b1;
      end

      if (break_stop_wait_flag_clear_i) begin
         s_nxt.break_stop_wait_flag = 1'b0;
      end
      if (break_exit_i) begin
         s_nxt.in_break = 1'b0;
      end

      if (any_rst) begin
         s_nxt.mode = SIL_RUN;
         s_nxt.in_break = 1'b0;
         s_nxt.wake_brk = 1'b0;
         s_nxt.rst_req = 1'b1;
      end else begin
         unique case (s.mode)
            SIL_RUN: begin
               if (break_irq_i && !s.in_break) begin
                  s_nxt.in_break = 1'b1;
                  s_nxt.stack = 1'b1;
                  s_nxt.vec_swi = 1'b1;
               end else if (cpu_swi_i) begin
                  // taken whatever the mask bit says
                  s_nxt.stack = 1'b1;
                  s_nxt.vec_swi = 1'b1;
               end else if (cpu_wait_i) begin
                  s_nxt.mode = SIL_WAIT;
                  s_nxt.mask_clr = 1'b1;
               end else if (cpu_stop_i) begin
                  s_nxt.mode = SIL_STOP;
                  s_nxt.mask_clr = 1'b1;
               end
            end
            SIL_WAIT: begin
               if (break_irq_i) begin
                  s_nxt.mode = SIL_RUN;
                  s_nxt.break_stop_wait_flag = 1'b1;
                  s_nxt.in_break = 1'b1;
                  s_nxt.stack = 1'b1;
                  s_nxt.vec_swi = 1'b1;
               end else if (irq_req_i) begin
                  s_nxt.mode = SIL_RUN;
                  s_nxt.stack = 1'b1;
               end
            end
            SIL_STOP: begin
               if (break_irq_i || irq_req_i) begin
                  s_nxt.mode = SIL_RECOV;
                  s_nxt.wake_brk = break_irq_i;
                  if (break_irq_i) begin
                     s_nxt.break_stop_wait_flag = 1'b1;
                  end
               end
            end
            SIL_RECOV: begin
               if (rec_done) begin
                  s_nxt.mode = SIL_RUN;
                  s_nxt.stack = 1'b1;
                  s_nxt.vec_swi = s.wake_brk;
                  s_nxt.in_break = s.in_break || s.wake_brk;
                  s_nxt.wake_brk = 1'b0;
               end
            end
         endcase
      end

      // peripherals gate their flag clears on this; a second step held off
      // here completes normally once break ends
      s_nxt.clr_allow = !s_nxt.in_break || s_nxt.break_clear_enable;
      s_nxt.wdog_en = !watchdog_disable_i;
      s_nxt.div = !s.div;
      s_nxt.clk.cpu_en = (s_nxt.mode == SIL_RUN);
      s_nxt.clk.periph_en = (s_nxt.mode == SIL_RUN) || (s_nxt.mode == SIL_WAIT);
      // oscillator must run in recovery, otherwise nothing times it
      s_nxt.clk.osc_x4_en = (s_nxt.mode != SIL_STOP);
      s_nxt.clk.osc_x2_en = s.div &&
                            (s_nxt.mode != SIL_STOP || osc_enable_in_stop_i);
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s <= SIL_ST_RESET;
      end else begin
         s <= s_nxt;
      end
   end

   assign reg_rdata_o = s.rdata;
   assign int_stack_o = s.stack;
   assign vector_swi_o = s.vec_swi;
   assign mask_clear_o = s.mask_clr;
   assign break_state_o = s.in_break;
   assign sys_reset_o = s.rst_req;
   assign break_stop_wait_flag_o = s.break_stop_wait_flag;
   assign flag_clear_allow_o = s.clr_allow;
   assign clk_en_o = s.clk;
   assign watchdog_en_o = s.wdog_en;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   property p_rst_any;
      (rst_src_i.wdog || rst_src_i.illop || rst_src_i.illegal_address_flag) |=> sys_reset_o && s.mode == SIL_RUN;
   endproperty
   a_rst_any: assert property (p_rst_any) else $error("reset source without reset request");

   property p_brk_swi;
      (s.mode == SIL_RUN && break_irq_i && !s.in_break && !any_rst)
         |=> int_stack_o && vector_swi_o && break_state_o;
   endproperty
   a_brk_swi: assert property (p_brk_swi) else $error("break did not force swi vector");

   property p_protect;
      (break_state_o && !s.break_clear_enable) |-> !flag_clear_allow_o;
   endproperty
   a_protect: assert property (p_protect) else $error("flags clearable in protected break");

   property p_wait_entry;
      (s.mode == SIL_RUN && cpu_wait_i && !cpu_swi_i && !break_irq_i && !any_rst)
         |=> mask_clear_o && !clk_en_o.cpu_en && clk_en_o.periph_en ##1 !mask_clear_o;
   endproperty
   a_wait_entry: assert property (p_wait_entry) else $error("wait entry clocks wrong");

   property p_wait_wake;
      (s.mode == SIL_WAIT && irq_req_i && !break_irq_i && !any_rst)
         |=> int_stack_o && !vector_swi_o && clk_en_o.cpu_en;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("wait wakeup stacking late");

   property p_wait_brk;
      (s.mode == SIL_WAIT && break_irq_i && !any_rst && !break_stop_wait_flag_clear_i)
         |=> break_stop_wait_flag_o && int_stack_o;
   endproperty
   a_wait_brk: assert property (p_wait_brk) else $error("break in wait not flagged");

   property p_stop_clk;
      (s.mode == SIL_STOP) |-> !clk_en_o.osc_x4_en && !clk_en_o.cpu_en &&
                               (!clk_en_o.osc_x2_en || osc_enable_in_stop_i || $past(osc_enable_in_stop_i));
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("oscillator running in stop");

   property p_recov_short;
      ($rose(s.mode == SIL_RECOV) && short_recovery_select_i)
         |-> !int_stack_o throughout (##[30:31] 1'b1) ##[1:4] int_stack_o;
   endproperty
   a_recov_short: assert property (p_recov_short) else $error("short recovery length wrong");

   property p_stat_clear;
      (rd_stat && !any_rst) |=> s.rst_stat == 8'h00 ##1 (s.rst_stat == 8'h00 || $past(any_rst));
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

   // the edge that releases reset still loads the reset value
   property p_wdog;
      !$past(reset_i) |-> watchdog_en_o == !$past(watchdog_disable_i);
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog enable does not follow bit");

   c_wait_wake: cover property (s.mode == SIL_WAIT ##1 int_stack_o);
   c_stop_recov: cover property (s.mode == SIL_RECOV ##1 s.mode == SIL_RUN);
   c_brk_protect: cover property (break_state_o && !flag_clear_allow_o);
   c_stat_read: cover property (rd_stat ##1 reg_rdata_o != 8'h00);

endmodule : sil_ctl

// *** sil_cpu_model.sv ***
`timescale 1ns/1ps
module sil_cpu_model
   import sil_pkg::*;
(
   // clock
   input wire logic ref_clk_i,
   // cpu instruction strobes
   output logic cpu_wait_o,
   output logic cpu_stop_o,
   output logic cpu_swi_o,
   // peripherals and break module
   output logic irq_req_o,
   output logic break_irq_o,
   output logic break_exit_o,
   output logic break_stop_wait_flag_clear_o
);
   logic [5:0] ev_r = 6'h00;
   initial irq_req_o = 1'b0;
   assign {break_stop_wait_flag_clear_o, break_exit_o, break_irq_o, cpu_swi_o, cpu_stop_o, cpu_wait_o} = ev_r;
   // 0 wait, 1 stop, 2 swi, 3 break, 4 break exit, 5 flag clear; one cycle each
   task automatic fire(input int k);
      @(posedge ref_clk_i);
      ev_r <= 6'h01 << k;
      @(posedge ref_clk_i);
      ev_r <= 6'h00;
   endtask : fire
   // enabled module interrupt, held as a level
   task automatic irq(input logic v);
      @(posedge ref_clk_i);
      irq_req_o <= v;
   endtask : irq
endmodule : sil_cpu_model

// *** system_lowpower_reset_break_ctl_test.sv ***
`timescale 1ns/1ps
module system_lowpower_reset_break_ctl_test;
   import sil_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_i;
   logic [7:0] addr, wdata, rdata, vhi, vlo;
   logic wr, rd, pin, low_voltage_flag, vtst, mon;
   logic wdis, short_recovery_select, oscen;
   logic c_wait, c_stop, c_swi, irq, brk, bexit, sbclr;
   logic stack, vswi, mclr, bstate, sysrst, break_stop_wait_flag, allow, wen, x2seen;
   sil_rst_src_t rsrc;
   sil_clk_t clken;
   int failures = 0, n_compared = 0, cyc = 0, exp_stat, n, t, d;
   int srcq[$];

   sil_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .cpu_wait_o(c_wait), .cpu_stop_o(c_stop),
      .cpu_swi_o(c_swi), .irq_req_o(irq), .break_irq_o(brk), .break_exit_o(bexit),
      .break_stop_wait_flag_clear_o(sbclr));

   sil_ctl u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .cpu_wait_i(c_wait), .cpu_stop_i(c_stop), .cpu_swi_i(c_swi), .int_stack_o(stack),
      .vector_swi_o(vswi), .mask_clear_o(mclr), .break_state_o(bstate),
      .sys_reset_o(sysrst), .irq_req_i(irq), .break_irq_i(brk), .break_exit_i(bexit),
      .break_stop_wait_flag_clear_i(sbclr), .break_stop_wait_flag_o(break_stop_wait_flag), .flag_clear_allow_o(allow),
      .rst_src_i(rsrc), .rst_pin_i(pin), .lvi_pin_i(low_voltage_flag), .irq_vtst_i(vtst),
      .mon_check_i(mon), .vec_hi_i(vhi), .vec_lo_i(vlo), .watchdog_disable_i(wdis),
      .short_recovery_select_i(short_recovery_select), .osc_enable_in_stop_i(oscen), .clk_en_o(clken),
      .watchdog_en_o(wen));

   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic end_of_test();
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string what, input logic exp, input logic got);
      chk8(what, {7'h00, exp}, {7'h00, got});
   endtask : chk1

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= dv;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask : reg_wr

   // read data are looked at only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 chk8(what, exp, rdata);
   endtask : reg_rd

   initial begin
      void'($urandom(32'h8D004F9C));
      reset_i <= 1'b1;
      {addr, wdata, vhi, vlo} <= 32'h0000_0000;
      {wr, rd, pin, low_voltage_flag, vtst, mon, wdis, short_recovery_select, oscen} <= 9'h000;
      rsrc <= '0;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      exp_stat = SIL_RST_STAT_RESET;
      @(posedge ref_clk_i);
      mon <= 1'b1;
      vhi <= SIL_VEC_ERASED;
      vlo <= SIL_VEC_ERASED;
      @(posedge ref_clk_i);
      mon <= 1'b0;
      // vector bytes no longer qualified: scramble them
      vhi <= 8'($urandom);
      vlo <= 8'($urandom);
      exp_stat |= 1 << SIL_BIT_MON;
      reg_rd(SIL_ADDR_RST_STAT, 8'(exp_stat), "status");
      reg_rd(SIL_ADDR_RST_STAT, 8'h00, "status");
      reg_wr(SIL_ADDR_RST_STAT, 8'hFF);
      reg_rd(SIL_ADDR_RST_STAT, 8'h00, "status");
      reg_rd(8'(2 + $urandom % 254), 8'h00, "unmapped");
      reg_rd(SIL_ADDR_BRK_CTL, {SIL_BREAK_CLEAR_ENABLE_RESET, 7'h00}, "bfc");
      d = $urandom;
      reg_wr(SIL_ADDR_BRK_CTL, 8'(d));
      reg_rd(SIL_ADDR_BRK_CTL, {d[7], 7'h00}, "bfc");
      // simultaneous sources are all taken, none wins
      @(posedge ref_clk_i);
      rsrc <= '{wdog: 1'b1, illop: 1'b1, illegal_address_flag: 1'b0};
      @(posedge ref_clk_i);
      rsrc <= '{wdog: 1'b0, illop: 1'b0, illegal_address_flag: 1'b1};
      #1 chk1("sysrst", 1'b1, sysrst);
      @(posedge ref_clk_i);
      rsrc <= '0;
      pin <= 1'b1;
      low_voltage_flag <= 1'b1;
      #1 chk1("sysrst", 1'b1, sysrst);
      repeat (4) @(posedge ref_clk_i);
      pin <= 1'b0;
      low_voltage_flag <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      srcq = '{SIL_BIT_WDOG, SIL_BIT_ILLOP, SIL_BIT_ILLEGAL_ADDRESS_FLAG, SIL_BIT_PIN, SIL_BIT_LVI};
      exp_stat = 0;
      foreach (srcq[i]) exp_stat |= 1 << srcq[i];
      reg_rd(SIL_ADDR_RST_STAT, 8'(exp_stat), "status");
      // wait, woken by interrupt
      u_cpu.fire(0);
      #1 chk1("mclr", 1'b1, mclr);
      chk1("cpu_en", 1'b0, clken.cpu_en);
      chk1("periph_en", 1'b1, clken.periph_en);
      chk1("wdog_en", ~wdis, wen);
      u_cpu.irq(1'b1);
      @(posedge ref_clk_i);
      #1 chk1("stack", 1'b1, stack);
      chk1("cpu_en", 1'b1, clken.cpu_en);
      u_cpu.irq(1'b0);
      // wait left by break, flags protected until enabled
      reg_wr(SIL_ADDR_BRK_CTL, 8'h00);
      u_cpu.fire(0);
      u_cpu.fire(3);
      #1 chk1("break_stop_wait_flag", 1'b1, break_stop_wait_flag);
      chk1("vswi", 1'b1, vswi);
      @(posedge ref_clk_i);
      #1 chk1("bstate", 1'b1, bstate);
      chk1("allow", 1'b0, allow);
      reg_wr(SIL_ADDR_BRK_CTL, 8'h80);
      @(posedge ref_clk_i);
      #1 chk1("allow", 1'b1, allow);
      reg_wr(SIL_ADDR_BRK_CTL, 8'h00);
      u_cpu.fire(4);
      @(posedge ref_clk_i);
      #1 chk1("bstate", 1'b0, bstate);
      chk1("allow", 1'b1, allow);
      u_cpu.fire(2);
      #1 chk1("swi", 1'b1, stack & vswi);
      u_cpu.fire(5);
      #1 chk1("break_stop_wait_flag", 1'b0, break_stop_wait_flag);
      // stop, short then long recovery
      for (int s = 1; s >= 0; s--) begin
         @(posedge ref_clk_i);
         short_recovery_select <= s[0];
         oscen <= s[0];
         wdis <= s[0];
         u_cpu.fire(1);
         #1 chk1("mclr", 1'b1, mclr);
         chk1("wdog_en", ~wdis, wen);
         chk1("x4_en", 1'b0, clken.osc_x4_en | clken.cpu_en);
         x2seen = 1'b0;
         // the counter is held however long stop lasts
         repeat (2 + $urandom % 20) begin
            @(posedge ref_clk_i);
            #1 x2seen |= clken.osc_x2_en;
         end
         chk1("x2_en", s[0], x2seen);
         u_cpu.irq(1'b1);
         t = s ? 32 : 4096;
         n = 0;
         while (stack !== 1'b1 && n < t + 10) begin
            @(posedge ref_clk_i);
            #1 n++;
         end
         chk1("recovery", 1'b1, n >= t && n <= t + 4);
         u_cpu.irq(1'b0);
      end
      // second power-on with the irq pin at test voltage: no monitor flag
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      vtst <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      mon <= 1'b1;
      vhi <= SIL_VEC_ERASED;
      vlo <= SIL_VEC_ERASED;
      @(posedge ref_clk_i);
      mon <= 1'b0;
      #1 chk1("sysrst", 1'b0, sysrst);
      reg_rd(SIL_ADDR_RST_STAT, SIL_RST_STAT_RESET, "status");
      end_of_test();
   end
endmodule : system_lowpower_reset_break_ctl_test
